// file: ulm_consts.vh
// Constants for the per-channel UART register block: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
`ifndef ULM_CONSTS_VH
`define ULM_CONSTS_VH

`define ULM_IDX_DIV_LO   4'h0
`define ULM_IDX_RXD      4'h0
`define ULM_IDX_DIV_HI   4'h1
`define ULM_IDX_LINE_CTL 4'h3
`define ULM_IDX_MDM_CTL  4'h4
`define ULM_IDX_LINE_ST  4'h5
`define ULM_IDX_MDM_ST   4'h6
`define ULM_IDX_SCR      4'h7
`define ULM_IDX_IST      4'h8
`define ULM_IDX_IMSK     4'h9

`define ULM_LC_DIV_ACC   7
`define ULM_LC_KEY       8'hbf
`define ULM_MC_DTR       0
`define ULM_MC_RTS       1
`define ULM_MC_LOOP      4
`define ULM_MC_HIDE      6

`define ULM_LS_DR        0
`define ULM_LS_OE        1
`define ULM_LS_PE        2
`define ULM_LS_FE        3
`define ULM_LS_BI        4

`define ULM_INT_DATA     0
`define ULM_INT_LINE     1
`define ULM_INT_MODEM    2

`define ULM_RST_DIV_LO   8'h01
`define ULM_RST_DIV_HI   8'h00
`define ULM_RST_SCR      8'hff
`define ULM_RST_LINE_CTL 8'h00
`define ULM_RST_MDM_CTL  8'h00
`define ULM_RST_INT      3'h0

`define ULM_FIFO_AW      6
`define ULM_FIFO_DW      11

`endif

// file: ulm_rx_fifo.v
// Receive store: 64 entries of data byte plus break, framing, parity flags.
// Assumes the caller never pushes while full nor pops while empty.
`timescale 1ns/1ps
`include "ulm_consts.vh"
module ulm_rx_fifo (
	input  wire                      clk_i,
	input  wire                      rst_i,
	input  wire                      push_i,
	input  wire [`ULM_FIFO_DW-1:0]   data_i,
	input  wire                      pop_i,
	output wire [`ULM_FIFO_DW-1:0]   data_o,
	output wire                      empty_o,
	output wire                      full_o
);
	reg [`ULM_FIFO_DW-1:0] mem [0:(1<<`ULM_FIFO_AW)-1];
	reg [`ULM_FIFO_AW-1:0] wr_ptr_ff;
	reg [`ULM_FIFO_AW-1:0] rd_ptr_ff;
	reg [`ULM_FIFO_AW:0]   count_ff;
	wire do_push;
	wire do_pop;

	assign do_push = push_i & ~full_o;
	assign do_pop  = pop_i & ~empty_o;
	assign data_o  = mem[rd_ptr_ff];
	assign empty_o = (count_ff == 0);
	assign full_o  = count_ff[`ULM_FIFO_AW];

	// Flags stored beside each byte
	always @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_ptr_ff] <= data_i;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_ff <= {`ULM_FIFO_AW{1'b0}};
			rd_ptr_ff <= {`ULM_FIFO_AW{1'b0}};
			count_ff  <= {(`ULM_FIFO_AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (do_push & ~do_pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (do_pop & ~do_push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule // ulm_rx_fifo

// file: ulm_modem_status.v
// Modem status byte: line levels in bits 7..4, sticky deltas in bits 3..0.
// Assumes modem inputs are synchronous to clk_i.
`timescale 1ns/1ps
`include "ulm_consts.vh"
module ulm_modem_status (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       loop_i,
	input  wire [3:0] ctl_i,
	input  wire       cd_n_i,
	input  wire       ri_n_i,
	input  wire       dsr_n_i,
	input  wire       cts_n_i,
	input  wire       clr_i,
	output wire [7:0] status_o
);
	reg  [3:0] lvl_ff;
	wire [3:0] cur;
	wire [3:0] nxt_delta;
	reg  [3:0] delta_ff;

	// Order: CD, RI, DSR, CTS
	assign cur = loop_i ? {ctl_i[3], ctl_i[2], ctl_i[0], ctl_i[1]}
	                    : ~{cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
	assign status_o = {lvl_ff, delta_ff};

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_delta
			wire edge_seen;
			if (i == 2) begin : g_ri
				// RI line rising means status bit falling
				assign edge_seen = lvl_ff[i] & ~cur[i];
			end else begin : g_any
				assign edge_seen = lvl_ff[i] ^ cur[i];
			end
			// Set wins over the read clear
			assign nxt_delta[i] = edge_seen | (delta_ff[i] & ~clr_i);
		end
	endgenerate

	always @(posedge clk_i) begin
		if (rst_i) begin
			lvl_ff   <= cur;
			delta_ff <= 4'h0;
		end else begin
			lvl_ff   <= cur;
			delta_ff <= nxt_delta;
		end
	end
endmodule // ulm_modem_status

// file: ulm_uart_regs.v
// UART channel register block: divisor, line and modem status, scratch, irq.
// Assumes a classic Wishbone master and a receiver that delivers characters
// as one-cycle strobes with their error flags.
`timescale 1ns/1ps
`include "ulm_consts.vh"
module ulm_uart_regs (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        soft_rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [5:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire        ack_o,
	input  wire        rx_valid_i,
	input  wire [7:0]  rx_data_i,
	input  wire        rx_brk_i,
	input  wire        rx_frm_i,
	input  wire        rx_par_i,
	input  wire        tx_serial_i,
	input  wire        rx_pin_i,
	output wire        rx_serial_o,
	output wire        tx_pin_o,
	input  wire        cd_n_i,
	input  wire        ri_n_i,
	input  wire        dsr_n_i,
	input  wire        cts_n_i,
	output wire        rts_n_o,
	output wire        dtr_n_o,
	output wire [15:0] divisor_o,
	output wire        irq_o
);
	// Bus registers
	reg  [7:0]  rd_byte_ff;
	reg         ack_ff;
	reg  [7:0]  nxt_rd_byte;

	// Software registers
	reg  [7:0]  div_lo_ff;
	reg  [7:0]  div_hi_ff;
	reg  [7:0]  line_ctl_ff;
	reg  [7:0]  mdm_ctl_ff;
	reg  [7:0]  scr_ff;
	reg  [2:0]  int_stat_ff;
	reg  [2:0]  int_mask_ff;
	reg  [7:0]  nxt_div_lo;
	reg  [7:0]  nxt_div_hi;
	reg  [7:0]  nxt_line_ctl;
	reg  [7:0]  nxt_mdm_ctl;
	reg  [7:0]  nxt_scr;
	reg  [2:0]  nxt_int_mask;
	wire [2:0]  nxt_int_stat;

	// Receive status
	reg         ovr_ff;
	wire        nxt_ovr;

	// Pin and output registers
	reg         rx_serial_ff;
	reg         tx_pin_ff;
	reg         rts_n_ff;
	reg         dtr_n_ff;
	reg         irq_ff;

	// Decode
	wire        req;
	wire        wr;
	wire        rd;
	wire [3:0]  idx;
	wire        loop;
	wire        dlab;
	wire        div_map;
	wire        low_map;
	wire        mdm_map;
	wire        any_rst;

	// Receive path
	wire [10:0] head;
	wire        rx_empty;
	wire        rx_full;
	wire        push;
	wire        pop;
	wire        ovr_set;
	wire        line_st_rd;
	wire        mdm_st_rd;
	wire        ist_rd;
	wire [7:0]  line_st;
	wire [7:0]  mdm_st;
	wire [2:0]  int_set;

	assign any_rst = rst_i | soft_rst_i;
	assign req     = cyc_i & stb_i & ~ack_ff;
	assign wr      = req & we_i & sel_i[0];
	assign rd      = req & ~we_i;
	assign idx     = adr_i[5:2];
	assign loop    = mdm_ctl_ff[`ULM_MC_LOOP];
	assign dlab    = line_ctl_ff[`ULM_LC_DIV_ACC];
	assign div_map = dlab & (line_ctl_ff != `ULM_LC_KEY);
	assign low_map = ~dlab;
	assign mdm_map = low_map & ~mdm_ctl_ff[`ULM_MC_HIDE];

	// Overrun drops the character instead of storing it
	assign push    = rx_valid_i & ~rx_full;
	assign ovr_set = rx_valid_i & rx_full;

	assign pop     = rd & (idx == `ULM_IDX_RXD) & low_map & ~rx_empty;
	assign line_st_rd = rd & (idx == `ULM_IDX_LINE_ST) & low_map;
	assign mdm_st_rd  = rd & (idx == `ULM_IDX_MDM_ST) & mdm_map;
	assign ist_rd  = rd & (idx == `ULM_IDX_IST);

	ulm_rx_fifo u_rx_fifo (
		.clk_i   (clk_i),
		.rst_i   (any_rst),
		.push_i  (push),
		.data_i  ({rx_brk_i, rx_frm_i, rx_par_i, rx_data_i}),
		.pop_i   (pop),
		.data_o  (head),
		.empty_o (rx_empty),
		.full_o  (rx_full)
	);

	ulm_modem_status u_modem (
		.clk_i   (clk_i),
		.rst_i   (any_rst),
		.loop_i  (loop),
		.ctl_i   (mdm_ctl_ff[3:0]),
		.cd_n_i  (cd_n_i),
		.ri_n_i  (ri_n_i),
		.dsr_n_i (dsr_n_i),
		.cts_n_i (cts_n_i),
		.clr_i   (mdm_st_rd),
		.status_o (mdm_st)
	);

	// Line status built from the head entry and the overrun flag
	assign line_st[7:5]          = 3'h0;
	assign line_st[`ULM_LS_BI] = head[10] & ~rx_empty;
	assign line_st[`ULM_LS_FE] = head[9] & ~rx_empty;
	assign line_st[`ULM_LS_PE] = head[8] & ~rx_empty;
	assign line_st[`ULM_LS_OE] = ovr_ff;
	assign line_st[`ULM_LS_DR] = ~rx_empty;

	// Overrun stays until line status is read; a new one wins
	assign nxt_ovr = ovr_set | (ovr_ff & ~line_st_rd);

	// Interrupt events
	assign int_set[`ULM_INT_DATA]  = ~rx_empty;
	assign int_set[`ULM_INT_LINE]  = ovr_set
		| (push & (rx_brk_i | rx_frm_i | rx_par_i));
	assign int_set[`ULM_INT_MODEM] = |mdm_st[3:0];
	assign nxt_int_stat = int_set | (int_stat_ff & ~{3{ist_rd}});

	// Read data select
	always @* begin
		nxt_rd_byte = 8'h00;
		if (idx == `ULM_IDX_DIV_LO && div_map) begin
			nxt_rd_byte = div_lo_ff;
		end else if (idx == `ULM_IDX_RXD && low_map) begin
			nxt_rd_byte = head[7:0] & {8{~rx_empty}};
		end else if (idx == `ULM_IDX_DIV_HI && div_map) begin
			nxt_rd_byte = div_hi_ff;
		end else if (idx == `ULM_IDX_LINE_CTL) begin
			nxt_rd_byte = line_ctl_ff;
		end else if (idx == `ULM_IDX_MDM_CTL) begin
			nxt_rd_byte = mdm_ctl_ff;
		end else if (idx == `ULM_IDX_LINE_ST && low_map) begin
			nxt_rd_byte = line_st;
		end else if (idx == `ULM_IDX_MDM_ST && mdm_map) begin
			nxt_rd_byte = mdm_st;
		end else if (idx == `ULM_IDX_SCR && mdm_map) begin
			nxt_rd_byte = scr_ff;
		end else if (idx == `ULM_IDX_IST) begin
			nxt_rd_byte = {5'h00, int_stat_ff};
		end else if (idx == `ULM_IDX_IMSK) begin
			nxt_rd_byte = {5'h00, int_mask_ff};
		end
	end

	// Register writes
	always @* begin
		nxt_div_lo   = div_lo_ff;
		nxt_div_hi   = div_hi_ff;
		nxt_line_ctl = line_ctl_ff;
		nxt_mdm_ctl  = mdm_ctl_ff;
		nxt_scr      = scr_ff;
		nxt_int_mask = int_mask_ff;
		if (wr) begin
			if (idx == `ULM_IDX_DIV_LO && div_map) begin
				nxt_div_lo = dat_i[7:0];
			end else if (idx == `ULM_IDX_DIV_HI && div_map) begin
				nxt_div_hi = dat_i[7:0];
			end else if (idx == `ULM_IDX_LINE_CTL) begin
				nxt_line_ctl = dat_i[7:0];
			end else if (idx == `ULM_IDX_MDM_CTL) begin
				nxt_mdm_ctl = dat_i[7:0];
			end else if (idx == `ULM_IDX_SCR && mdm_map) begin
				nxt_scr = dat_i[7:0];
			end else if (idx == `ULM_IDX_IMSK) begin
				nxt_int_mask = dat_i[2:0];
			end
		end
	end

	// Bus answer: one wait state, data and ack registered
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff     <= 1'b0;
			rd_byte_ff <= 8'h00;
		end else begin
			ack_ff <= req;
			if (rd) begin
				rd_byte_ff <= nxt_rd_byte;
			end
		end
	end

	// Divisor survives soft reset
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_lo_ff <= `ULM_RST_DIV_LO;
			div_hi_ff <= `ULM_RST_DIV_HI;
		end else begin
			div_lo_ff <= nxt_div_lo;
			div_hi_ff <= nxt_div_hi;
		end
	end

	// Control, scratch and status registers
	always @(posedge clk_i) begin
		if (any_rst) begin
			line_ctl_ff <= `ULM_RST_LINE_CTL;
			mdm_ctl_ff  <= `ULM_RST_MDM_CTL;
			scr_ff      <= `ULM_RST_SCR;
			int_stat_ff <= `ULM_RST_INT;
			int_mask_ff <= `ULM_RST_INT;
			ovr_ff      <= 1'b0;
		end else begin
			line_ctl_ff <= nxt_line_ctl;
			mdm_ctl_ff  <= nxt_mdm_ctl;
			scr_ff      <= nxt_scr;
			int_stat_ff <= nxt_int_stat;
			int_mask_ff <= nxt_int_mask;
			ovr_ff      <= nxt_ovr;
		end
	end

	// Pins: loopback feeds transmit to receive, idles the line outputs
	always @(posedge clk_i) begin
		if (any_rst) begin
			rx_serial_ff <= 1'b1;
			tx_pin_ff    <= 1'b1;
			rts_n_ff     <= 1'b1;
			dtr_n_ff     <= 1'b1;
			irq_ff       <= 1'b0;
		end else begin
			rx_serial_ff <= loop ? tx_serial_i : rx_pin_i;
			tx_pin_ff    <= loop | tx_serial_i;
			rts_n_ff     <= loop | ~mdm_ctl_ff[`ULM_MC_RTS];
			dtr_n_ff     <= loop | ~mdm_ctl_ff[`ULM_MC_DTR];
			irq_ff       <= |(int_stat_ff & int_mask_ff);
		end
	end

	assign dat_o       = {24'h00_0000, rd_byte_ff};
	assign ack_o       = ack_ff;
	assign divisor_o   = {div_hi_ff, div_lo_ff};
	assign rx_serial_o = rx_serial_ff;
	assign tx_pin_o    = tx_pin_ff;
	assign rts_n_o     = rts_n_ff;
	assign dtr_n_o     = dtr_n_ff;
	assign irq_o       = irq_ff;
endmodule // ulm_uart_regs

// file: ulm_uart_regs_assertions.sv
// Checker for the register block: bus answer, divisor, line path.
// Assumes a bind to ulm_uart_regs and sees only its ports.
`timescale 1ns/1ps
module ulm_uart_regs_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        soft_rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [3:0]  sel_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        tx_serial_i,
	input wire        rx_pin_i,
	input wire        rx_serial_o,
	input wire        tx_pin_o,
	input wire        rts_n_o,
	input wire [15:0] divisor_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || soft_rst_i);
	reg wr_seen_ff;
	always @(posedge clk_i) begin
		wr_seen_ff <= cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
	end
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_answer;
		ack_o ##1 !ack_o;
	endsequence
	chk_ack_answer: assert property (s_take |=> s_answer)
		else $error("request not answered by one ack");
	chk_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
		else $error("ack without a request");
	chk_data_width: assert property (ack_o |-> dat_o[31:8] == '0)
		else $error("read data above bit 7");
	chk_div_reset: assert property ($fell(rst_i) |-> divisor_o == 16'h0001)
		else $error("divisor not 0001 after reset");
	chk_div_soft: assert property (disable iff (rst_i)
		soft_rst_i |=> $stable(divisor_o)) else $error("soft reset moved divisor");
	chk_div_write: assert property (disable iff (rst_i)
		$changed(divisor_o) |-> wr_seen_ff) else $error("divisor moved unasked");
	chk_rx_path: assert property (!tx_pin_o |-> rx_serial_o == $past(rx_pin_i))
		else $error("line pin not routed to receiver");
	chk_tx_path: assert property (!rts_n_o |-> tx_pin_o == $past(tx_serial_i))
		else $error("transmit not on pin outside loopback");
endmodule // ulm_uart_regs_chk
bind ulm_uart_regs ulm_uart_regs_chk u_chk (.*);

// file: ulm_modem_model.sv
// Modem side: drives the four active-low modem lines on request.
// Assumes requests change right after a rising clock edge.
`timescale 1ns/1ps
module ulm_modem_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] on_i,
	output logic            cd_n_o,
	output logic            ri_n_o,
	output logic            dsr_n_o,
	output logic            cts_n_o
);
	// Lines move only at an edge, the block takes them as synchronous
	always @(posedge clk_i) begin
		{cd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= ~on_i;
	end
endmodule // ulm_modem_model

// file: ulm_uart_regs_tb.sv
// Self-checking bench for the register block over classic Wishbone.
// Assumes the modem model on the modem lines; bench drives the rest.
`timescale 1ns/1ps
module ulm_uart_regs_tb;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        soft_rst_i = 0;
	logic        cyc_i = 0;
	logic        stb_i = 0;
	logic        we_i = 0;
	logic [5:0]  adr_i = '0;
	logic [3:0]  sel_i = '0;
	logic [31:0] dat_i = '0;
	logic        rx_valid_i = 0;
	logic [7:0]  rx_data_i = '0;
	logic        rx_brk_i = 0;
	logic        rx_frm_i = 0;
	logic        rx_par_i = 0;
	logic        tx_serial_i = 1;
	logic        rx_pin_i = 1;
	logic [3:0]  mdm_on = 4'ha;
	logic [31:0] dat_o;
	logic [15:0] divisor_o;
	logic        ack_o, rx_serial_o, tx_pin_o, rts_n_o, dtr_n_o, irq_o;
	wire         cd_n_i, ri_n_i, dsr_n_i, cts_n_i;
	logic [7:0]  rd;
	int          bad_count = 0;
	int          total_checks = 0;
	int          i;
	ulm_uart_regs DUT (.*);
	ulm_modem_model MDM (.clk_i, .on_i(mdm_on), .cd_n_o(cd_n_i),
		.ri_n_o(ri_n_i), .dsr_n_o(dsr_n_i), .cts_n_o(cts_n_i));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
		int n;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= {idx, 2'h0};
		sel_i <= 4'hf;
		dat_i <= {24'h0, d};
		for (n = 0; n < 20 && ack_o !== 1'b1; n++)
			@(posedge clk_i);
		if (n == 20) begin
			bad_count++;
			$display("mismatch at %0t: no bus answer", $time);
			test_done;
		end
		rd = dat_o[7:0];
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
		wb(0, idx, 8'h00);
		chk(rd, exp);
	endtask
	task automatic mdm(input logic [3:0] on);
		mdm_on <= on;
		repeat (5) @(posedge clk_i);
	endtask
	task automatic rxc(input logic [7:0] d, input logic [2:0] f);
		rx_valid_i <= 1;
		rx_data_i <= d;
		{rx_brk_i, rx_frm_i, rx_par_i} <= f;
		@(posedge clk_i);
		rx_valid_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic t_reset;
		rdc(4'h7, 8'hff);
		rdc(4'h6, 8'ha0);
		mdm(4'h0);
		rdc(4'h6, 8'h0a);
		wb(1, 4'h3, 8'h80);
		rdc(4'h0, 8'h01);
		rdc(4'h1, 8'h00);
	endtask
	task automatic t_div;
		wb(1, 4'h0, 8'h34);
		wb(1, 4'h1, 8'h12);
		chk(divisor_o, 16'h1234);
		soft_rst_i <= 1;
		repeat (2) @(posedge clk_i);
		soft_rst_i <= 0;
		@(posedge clk_i);
		chk(divisor_o, 16'h1234);
		wb(1, 4'h3, 8'hbf);
		rdc(4'h1, 8'h00);
		wb(1, 4'h0, 8'h77);
		wb(1, 4'h3, 8'h80);
		rdc(4'h0, 8'h34);
		wb(1, 4'h3, 8'h00);
	endtask
	task automatic t_gate;
		wb(1, 4'h7, 8'h5a);
		rdc(4'h7, 8'h5a);
		wb(1, 4'h4, 8'h40);
		wb(1, 4'h7, 8'h00);
		rdc(4'h7, 8'h00);
		wb(1, 4'h4, 8'h00);
		rdc(4'h7, 8'h5a);
		wb(1, 4'h3, 8'h80);
		rdc(4'h6, 8'h00);
		wb(1, 4'h3, 8'h00);
	endtask
	task automatic t_modem;
		wb(0, 4'h8, 8'h00);
		mdm(4'h8);
		chk(irq_o, 1'b0);
		rdc(4'h6, 8'h88);
		mdm(4'h0);
		wb(0, 4'h6, 8'h00);
		wb(0, 4'h8, 8'h00);
		wb(1, 4'h9, 8'h04);
		for (i = 0; i < 4; i++) begin
			mdm(4'h1 << i);
			chk(irq_o, i != 2);
			rdc(4'h6, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i));
			rdc(4'h8, i == 2 ? 8'h00 : 8'h04);
			mdm(4'h0);
			rdc(4'h6, 8'h01 << i);
			rdc(4'h8, 8'h04);
			repeat (3) @(posedge clk_i);
			chk(irq_o, 1'b0);
		end
	endtask
	task automatic t_loop;
		wb(1, 4'h4, 8'h19);
		chk({tx_pin_o, rts_n_o, dtr_n_o}, 3'h7);
		tx_serial_i <= 0;
		repeat (2) @(posedge clk_i);
		chk(rx_serial_o, 1'b0);
		rdc(4'h6, 8'haa);
		mdm(4'hf);
		wb(1, 4'h4, 8'h16);
		rdc(4'h6, 8'h5b);
		wb(1, 4'h4, 8'h02);
		chk({tx_pin_o, rx_serial_o, rts_n_o, dtr_n_o}, 4'h5);
		rdc(4'h6, 8'hfa);
		tx_serial_i <= 1;
		mdm(4'h0);
		wb(0, 4'h6, 8'h00);
		wb(0, 4'h8, 8'h00);
	endtask
	task automatic t_rx;
		rxc(8'ha5, 3'h4);
		rxc(8'h3c, 3'h2);
		rxc(8'h0f, 3'h1);
		rdc(4'h5, 8'h11);
		rdc(4'h0, 8'ha5);
		rdc(4'h5, 8'h09);
		rdc(4'h0, 8'h3c);
		rdc(4'h5, 8'h05);
		rdc(4'h0, 8'h0f);
		rdc(4'h5, 8'h00);
		for (i = 0; i < 65; i++)
			rxc(i[7:0], 3'h0);
		rdc(4'h5, 8'h03);
		for (i = 0; i < 64; i++)
			rdc(4'h0, i[7:0]);
		rdc(4'h5, 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_reset;
		t_div;
		t_gate;
		t_modem;
		t_loop;
		t_rx;
		test_done;
	end
endmodule // ulm_uart_regs_tb
